// [plsr_asserts.sv]
// Concurrent checks on the pulser pins and channel switch states
`timescale 1ns/1ps
`default_nettype none
module plsr_asserts (
  input wire logic                                   clock,
  input wire logic                                   reset,
  input wire logic [11:0]                            channel_code,
  input wire logic                                   output_enable_n,
  input wire logic                                   clock_mode_select_n,
  input wire logic                                   link_clock,
  input wire logic                                   clock_negative,
  input wire logic                                   overtemp_flag_o,
  input wire logic                                   overtemp_flag_oe_n,
  input wire logic [7:0]                             die_temp_c,
  input wire plsr_pkg::plsr_sw_t [plsr_pkg::CH_NUM-1:0] ch_switch,
  input wire logic [1:0]                             drive_current_mode
);
  import plsr_pkg::*;
  localparam logic [11:0] EXP [8] = '{12'h002, 12'h242, 12'h005, 12'h802,
                                      12'h03a, 12'h182, 12'h03d, 12'h402};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  for (genvar g = 0; g < CH_NUM; g++) begin : g_ch
    a_disabled_safe: assert property (
      (output_enable_n && clock_mode_select_n) [*8] |-> ch_switch[g] == SW_SAFE)
      else $error("channel not safe while disabled");
    a_code_decode: assert property (
      (clock_mode_select_n && !output_enable_n && $stable(channel_code)) [*6]
      |-> ((ch_switch[g] ^ EXP[channel_code[3*g+:3]]) & 12'hf3d) == 12'h000)
      else $error("channel switch state differs from its code");
    a_assist_gated: assert property (
      drive_current_mode != 2'h3
      |-> !ch_switch[g].hv2_neg_assist_fet && !ch_switch[g].hv2_pos_assist_fet)
      else $error("assist transistor on outside drive mode 3");
  end

  a_flag_sets: assert property (die_temp_c > OT_SET_C |=> !overtemp_flag_oe_n)
    else $error("flag not pulled above threshold");
  a_flag_holds: assert property (
    !overtemp_flag_oe_n && die_temp_c > OT_SET_C - OT_HYST_C |=> !overtemp_flag_oe_n)
    else $error("flag released inside hysteresis");
  a_flag_clears: assert property (
    die_temp_c <= OT_SET_C - OT_HYST_C |=> overtemp_flag_oe_n)
    else $error("flag not released after cooling");
  a_flag_drain: assert property (overtemp_flag_o == 1'b0)
    else $error("flag driven high");
  a_clock_pair: assert property (clock_negative == !link_clock)
    else $error("clock pair not complementary");
  a_link_rate: assert property ($changed(link_clock) |=> $stable(link_clock))
    else $error("link clock toggles too fast");
endmodule : plsr_asserts
`default_nettype wire

// [plsr_beam.sv]
// Beamformer end: drives codes, straps and divided link clock
`timescale 1ns/1ps
`default_nettype none
module plsr_beam
  import plsr_pkg::*;
#(
  parameter int CLK_DIV = 2
)
(
  input  wire logic        clock,
  input  wire logic        reset,
  plsr_if.beam             pins,
  input  wire logic [11:0] user_code,
  input  wire logic        user_enable_n,
  input  wire logic        user_clocked,
  input  wire logic [1:0]  user_drive_sel,
  input  wire logic [1:0]  user_overlap_sel,
  input  wire logic [1:0]  user_edge_sel,
  input  wire logic        user_lvds,
  input  wire logic        user_term,
  output logic             burst_ready,
  output logic             overtemp
);
  import plsr_pkg::*;

  typedef struct packed {
    logic [11:0] code;
    logic        oe_n;
    logic        clksel_n;
    logic [7:0]  div_cnt;
    logic        lclk;
    logic [7:0]  gnd_cnt;
    logic [7:0]  en_cnt;
    logic        ready;
    logic [2:0]  ot_sync;
    logic        ot;
  } plsr_beam_state_t;

  plsr_beam_state_t st_r, st_nxt;

  always_comb begin
    logic all_gnd;
    all_gnd = (user_code == {4{CODE_GND}}) && !user_enable_n;
    st_nxt = st_r;
    st_nxt.code     = user_code;
    st_nxt.oe_n     = user_enable_n;
    st_nxt.clksel_n = !user_clocked;
    if (st_r.div_cnt == 8'(CLK_DIV - 1)) begin
      st_nxt.div_cnt = 8'h00;
      st_nxt.lclk    = !st_r.lclk;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 8'h01;
    end
    if (!all_gnd) begin
      st_nxt.gnd_cnt = 8'h00;
    end else if (st_r.gnd_cnt != 8'(TX_SETUP_CYC)) begin
      st_nxt.gnd_cnt = st_r.gnd_cnt + 8'h01;
    end
    if (!user_clocked) begin
      st_nxt.en_cnt = 8'h00;
    end else if (st_r.en_cnt != 8'(CLOCK_MODE_SELECT_N_CYC)) begin
      st_nxt.en_cnt = st_r.en_cnt + 8'h01;
    end
    st_nxt.ready = (st_nxt.gnd_cnt == 8'(TX_SETUP_CYC))
                && (!user_clocked || st_nxt.en_cnt == 8'(CLOCK_MODE_SELECT_N_CYC));
    st_nxt.ot_sync = {st_r.ot_sync[1:0], !pins.overtemp_flag_oe_n};
    if (st_r.ot_sync[1] == st_r.ot_sync[2]) begin
      st_nxt.ot = st_r.ot_sync[2];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '{code: 12'h000, oe_n: OE_N_RST, clksel_n: CLKSEL_RST, div_cnt: 8'h00,
                lclk: 1'b0, gnd_cnt: 8'h00, en_cnt: 8'h00, ready: 1'b0,
                ot_sync: 3'h0, ot: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins.channel_code            = st_r.code;
  assign pins.output_enable_n         = st_r.oe_n;
  assign pins.clock_mode_select_n     = st_r.clksel_n;
  assign pins.link_clock              = st_r.lclk;
  assign pins.clock_negative          = !st_r.lclk;
  assign pins.drive_strength_sel      = user_drive_sel;
  assign pins.rx_overlap_sel          = user_overlap_sel;
  assign pins.clock_edge_delay_sel    = user_edge_sel;
  assign pins.clock_interface_select  = !user_lvds;
  assign pins.diff_termination_select = user_term;
  assign burst_ready                  = st_r.ready;
  assign overtemp                     = st_r.ot;

endmodule : plsr_beam
`default_nettype wire

// [plsr_chan_decode.sv]
// One channel: code decode, overlap of receive switches
`timescale 1ns/1ps
`default_nettype none
module plsr_chan_decode
  import plsr_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic [2:0]    code,
  input  wire logic          enable_n,
  input  wire logic [1:0]    drive_sel,
  input  wire logic [1:0]    overlap_sel,
  output plsr_pkg::plsr_sw_t sw
);
  import plsr_pkg::*;

  typedef struct packed {
    plsr_sw_t    sw;
    logic [7:0]  ovl_cnt;
    logic        rx_prev;
  } plsr_ch_state_t;

  plsr_ch_state_t st_r, st_nxt;

  function automatic logic [7:0] ovl_cycles(input logic [1:0] sel);
    case (sel)
      2'h1:    ovl_cycles = 8'(OVL_CYC_1);
      2'h2:    ovl_cycles = 8'(OVL_CYC_2);
      2'h3:    ovl_cycles = 8'(OVL_CYC_3);
      default: ovl_cycles = 8'(OVL_NS_0);
    endcase
  endfunction : ovl_cycles

  always_comb begin
    plsr_sw_t t;
    logic     rx_on;
    t = SW_SAFE;
    st_nxt = st_r;
    rx_on = 1'b0;
    if (!enable_n) begin
      case (plsr_code_t'(code))
        CODE_IDLE: t = SW_SAFE;
        CODE_POS2: begin
          t.hv2_high_fet       = 1'b1;
          t.hv2_pos_assist_fet = 1'b1;
        end
        CODE_NEG2: begin
          t.hv2_low_fet        = 1'b1;
          t.hv2_neg_assist_fet = 1'b1;
        end
        CODE_POS1: t.hv1_high_fet = 1'b1;
        CODE_NEG1: t.hv1_low_fet  = 1'b1;
        CODE_RX: rx_on = 1'b1;
        CODE_GND: begin
          t.gnd_clamp_high_fet  = 1'b1;
          t.gnd_clamp_low_fet   = 1'b1;
          t.ground_bleed_switch = 1'b1;
        end
        CODE_GND_RX: begin
          t.gnd_clamp_high_fet  = 1'b1;
          t.gnd_clamp_low_fet   = 1'b1;
          t.ground_bleed_switch = 1'b1;
          rx_on = 1'b1;
        end
        default: t = SW_SAFE;
      endcase
    end
    if (drive_sel != DRIVE_RST) begin
      t.hv2_neg_assist_fet = 1'b0;
      t.hv2_pos_assist_fet = 1'b0;
    end
    if (rx_on) begin
      if (!st_r.rx_prev) begin
        st_nxt.ovl_cnt = ovl_cycles(overlap_sel);
      end else if (st_r.ovl_cnt != 8'h00) begin
        st_nxt.ovl_cnt = st_r.ovl_cnt - 8'h01;
      end
      t.rx_series_switch_first  = 1'b1;
      t.rx_series_switch_second = 1'b1;
      t.rx_shunt_switch = (!st_r.rx_prev) ? (ovl_cycles(overlap_sel) != 8'h00)
                                          : (st_r.ovl_cnt > 8'h01);
    end else begin
      st_nxt.ovl_cnt = 8'h00;
    end
    st_nxt.rx_prev = rx_on;
    st_nxt.sw = t;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '{sw: SW_SAFE, ovl_cnt: 8'h00, rx_prev: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sw = st_r.sw;

endmodule : plsr_chan_decode
`default_nettype wire

// [plsr_if.sv]
// Pin bundle between the beamformer end and the pulser end
`timescale 1ns/1ps
`default_nettype none
interface plsr_if;
  logic [11:0] channel_code;
  logic        output_enable_n;
  logic        clock_mode_select_n;
  logic        clock_interface_select;
  logic        diff_termination_select;
  logic [1:0]  clock_edge_delay_sel;
  logic [1:0]  drive_strength_sel;
  logic [1:0]  rx_overlap_sel;
  logic        link_clock;
  logic        clock_negative;
  logic        overtemp_flag_o;
  logic        overtemp_flag_oe_n;

  modport pulser (
    input  channel_code, output_enable_n, clock_mode_select_n, clock_interface_select,
    input  diff_termination_select, clock_edge_delay_sel, drive_strength_sel,
    input  rx_overlap_sel, link_clock, clock_negative,
    output overtemp_flag_o, overtemp_flag_oe_n
  );
  modport beam (
    output channel_code, output_enable_n, clock_mode_select_n, clock_interface_select,
    output diff_termination_select, clock_edge_delay_sel, drive_strength_sel,
    output rx_overlap_sel, link_clock, clock_negative,
    input  overtemp_flag_o, overtemp_flag_oe_n
  );
endinterface : plsr_if
`default_nettype wire

// [plsr_pkg.sv]
// Shared constants and types for the pulser channel mode control
package plsr_pkg;

  localparam int CLK_MHZ = 250;
  localparam int CH_NUM  = 4;

  // Overlap times of the first series switch and the shunt, in ns
  localparam int OVL_NS_0 = 0;
  localparam int OVL_NS_1 = 100;
  localparam int OVL_NS_2 = 200;
  localparam int OVL_NS_3 = 300;
  localparam int OVL_CYC_1 = (OVL_NS_1 * CLK_MHZ + 999) / 1000;
  localparam int OVL_CYC_2 = (OVL_NS_2 * CLK_MHZ + 999) / 1000;
  localparam int OVL_CYC_3 = (OVL_NS_3 * CLK_MHZ + 999) / 1000;

  // Ground clamp hold before a burst, in ns
  localparam int TX_SETUP_NS  = 100;
  localparam int TX_SETUP_CYC = (TX_SETUP_NS * CLK_MHZ + 999) / 1000;
  // Settle after clocked mode is enabled, in ns
  localparam int CLOCK_MODE_SELECT_N_NS     = 600;
  localparam int CLOCK_MODE_SELECT_N_CYC    = (CLOCK_MODE_SELECT_N_NS * CLK_MHZ + 999) / 1000;

  // Clock edge delay steps in ps; finer than one cycle, so edge_dly is captured but not applied
  localparam int EDGE_PS_STEP = 500;

  // Over-temperature threshold and hysteresis, degrees C
  localparam logic [7:0] OT_SET_C  = 8'h6e;
  localparam logic [7:0] OT_HYST_C = 8'h0a;

  // Strap values after reset (pull-ups and pull-downs)
  localparam logic [1:0] DRIVE_RST   = 2'h3;
  localparam logic [1:0] OVL_RST     = 2'h0;
  localparam logic [1:0] EDGE_RST    = 2'h0;
  localparam logic       CLKSEL_RST  = 1'h1;
  localparam logic       IFSEL_RST   = 1'h1;
  localparam logic       TERM_RST    = 1'h0;
  localparam logic       OE_N_RST    = 1'h1;

  typedef enum logic [2:0] {
    CODE_IDLE   = 3'b000,
    CODE_POS2   = 3'b001,
    CODE_RX     = 3'b010,
    CODE_POS1   = 3'b011,
    CODE_GND    = 3'b100,
    CODE_NEG2   = 3'b101,
    CODE_GND_RX = 3'b110,
    CODE_NEG1   = 3'b111
  } plsr_code_t;

  // Switch states for one channel, 1 = on
  typedef struct packed {
    logic hv1_high_fet;
    logic hv1_low_fet;
    logic hv2_high_fet;
    logic hv2_low_fet;
    logic hv2_neg_assist_fet;
    logic hv2_pos_assist_fet;
    logic gnd_clamp_high_fet;
    logic gnd_clamp_low_fet;
    logic ground_bleed_switch;
    logic rx_series_switch_first;
    logic rx_shunt_switch;
    logic rx_series_switch_second;
  } plsr_sw_t;

  localparam plsr_sw_t SW_SAFE = 12'h002;

endpackage : plsr_pkg

// [plsr_pulser.sv]
// Pulser end: strap capture, clocked or transparent input path, four channel decoders
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Disabled outputs leave only shunt on
// - Three-bit code per channel, bit2 MSB
// - Code 000 leaves only shunt on
// - Codes 001/101 drive second rail with assist
// - Codes 011/111 drive first rail only
// - Code 010 closes receive path
// - Code 100 clamps node to ground
// - Code 110 clamps and closes receive
// - Assists off unless drive mode 3
// - Drive strength selects four currents, default 3
// - Controller picks drive mode by load
// - Receive overlap 0-300 ns, default 0
// - Clock edge delay 0-1.5 ns, default 0; edge_dly is captured but not applied
// - Controller clamps ground 100 ns first
// - Clock mode select low means clocked
// - Interface select high means CMOS clock
// - Termination select high connects termination
// - Controller keeps clock at most 200 MHz
// - Over-temperature pulls flag low, with hysteresis
// - Controller waits 600 ns after clock enable
module plsr_pulser
  import plsr_pkg::*;
(
  input  wire logic                                  clock,
  input  wire logic                                  reset,
  plsr_if.pulser                                     pins,
  input  wire logic [7:0]                            die_temp_c,
  output plsr_pkg::plsr_sw_t [plsr_pkg::CH_NUM-1:0]  ch_switch,
  output logic [1:0]                                 drive_current_mode,
  output logic                                       clocked_active,
  output logic                                       lvds_selected,
  output logic                                       termination_on
);
  import plsr_pkg::*;

  typedef struct packed {
    logic [2:0][11:0] code_sync;
    logic [2:0]       oe_sync;
    logic [2:0]       clksel_sync;
    logic [2:0]       lclk_sync;
    logic [11:0]      code_hold;
    logic             oe_hold;
    logic [1:0]       edge_dly;
    logic [1:0]       drive_sel;
    logic [1:0]       ovl_sel;
    logic             clksel_n;
    logic             if_sel;
    logic             term_sel;
    logic             strap_done;
    logic             ot_active;
    logic             ot_oe_n;
    logic             clocked_act;
    logic             lvds_act;
  } plsr_dev_state_t;

  plsr_dev_state_t st_r, st_nxt;
  logic [11:0]     code_eff;
  logic            oe_eff;

  // The last two stages must agree before a change counts
  function automatic logic agreed(input logic s2, input logic s3, input logic cur);
    if (s2 == s3) begin
      agreed = s3;
    end else begin
      agreed = cur;
    end
  endfunction : agreed

  always_comb begin
    logic lclk_rise;
    lclk_rise = st_r.lclk_sync[1] && !st_r.lclk_sync[2];
    st_nxt = st_r;
    st_nxt.code_sync   = {st_r.code_sync[1:0], pins.channel_code};
    st_nxt.oe_sync     = {st_r.oe_sync[1:0], pins.output_enable_n};
    st_nxt.clksel_sync = {st_r.clksel_sync[1:0], pins.clock_mode_select_n};
    st_nxt.lclk_sync   = {st_r.lclk_sync[1:0], pins.link_clock};
    // Straps are caught once after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.drive_sel  = pins.drive_strength_sel;
      st_nxt.ovl_sel    = pins.rx_overlap_sel;
      st_nxt.edge_dly   = pins.clock_edge_delay_sel;
      st_nxt.if_sel     = pins.clock_interface_select;
      st_nxt.term_sel   = pins.diff_termination_select;
    end
    st_nxt.clksel_n = agreed(st_r.clksel_sync[1], st_r.clksel_sync[2], st_r.clksel_n);
    if (lclk_rise) begin
      st_nxt.code_hold = st_r.code_sync[2];
      st_nxt.oe_hold   = st_r.oe_sync[2];
    end
    if (die_temp_c > OT_SET_C) begin
      st_nxt.ot_active = 1'b1;
    end else if (die_temp_c <= OT_SET_C - OT_HYST_C) begin
      st_nxt.ot_active = 1'b0;
    end
    st_nxt.ot_oe_n = !st_nxt.ot_active;
    // Status outputs leave straight from flops
    st_nxt.clocked_act = !st_nxt.clksel_n;
    st_nxt.lvds_act    = !st_nxt.if_sel;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_r <= '{
        code_sync:   '0,
        oe_sync:     3'h7,
        clksel_sync: 3'h7,
        lclk_sync:   3'h0,
        code_hold:   12'h000,
        oe_hold:     OE_N_RST,
        edge_dly:    EDGE_RST,
        drive_sel:   DRIVE_RST,
        ovl_sel:     OVL_RST,
        clksel_n:    CLKSEL_RST,
        if_sel:      IFSEL_RST,
        term_sel:    TERM_RST,
        strap_done:  1'b0,
        ot_active:   1'b0,
        ot_oe_n:     1'b1,
        clocked_act: !CLKSEL_RST,
        lvds_act:    !IFSEL_RST
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  assign code_eff = st_r.clksel_n ? st_r.code_sync[2] : st_r.code_hold;
  assign oe_eff   = st_r.clksel_n ? st_r.oe_sync[2]   : st_r.oe_hold;

  for (genvar g = 0; g < CH_NUM; g++) begin : g_ch
    plsr_chan_decode i_plsr_chan_decode (
      .clock       (clock),
      .reset       (reset),
      .code        (code_eff[3*g +: 3]),
      .enable_n    (oe_eff),
      .drive_sel   (st_r.drive_sel),
      .overlap_sel (st_r.ovl_sel),
      .sw          (ch_switch[g])
    );
  end

  // Open drain: driven low, enable low while pulling
  assign pins.overtemp_flag_o    = 1'b0;
  assign pins.overtemp_flag_oe_n = st_r.ot_oe_n;
  assign drive_current_mode      = st_r.drive_sel;
  assign clocked_active          = st_r.clocked_act;
  assign lvds_selected           = st_r.lvds_act;
  assign termination_on          = st_r.term_sel;

endmodule : plsr_pulser
`default_nettype wire

// [pulser_channel_mode_control_test.sv]
// Self-checking bench joining the beamformer end and the pulser end
`timescale 1ns/1ps
`default_nettype none
module pulser_channel_mode_control_test;
  import plsr_pkg::*;
  localparam logic [11:0] EXP [8] = '{12'h002, 12'h242, 12'h005, 12'h802,
                                      12'h03a, 12'h182, 12'h03d, 12'h402};
  localparam int OVL [4] = '{OVL_NS_0, OVL_CYC_1, OVL_CYC_2, OVL_CYC_3};
  localparam int LIMIT = 20000;
  logic                  clock;
  logic                  reset;
  logic [11:0]           user_code;
  logic                  user_enable_n;
  logic                  user_clocked;
  logic [1:0]            user_drive_sel;
  logic [1:0]            user_overlap_sel;
  logic [1:0]            user_edge_sel;
  logic                  user_lvds;
  logic                  user_term;
  logic [7:0]            die_temp_c;
  plsr_sw_t [CH_NUM-1:0] ch_switch;
  logic [1:0]            drive_current_mode;
  logic                  clocked_active, lvds_selected, termination_on, burst_ready, overtemp;
  int                    bad_count = 0;
  int                    n_tests = 0;
  int                    cycles = 0;

  plsr_if link ();
  plsr_beam #(.CLK_DIV(2)) i_plsr_beam (.clock(clock), .reset(reset), .pins(link),
    .user_code(user_code), .user_enable_n(user_enable_n), .user_clocked(user_clocked),
    .user_drive_sel(user_drive_sel), .user_overlap_sel(user_overlap_sel),
    .user_edge_sel(user_edge_sel), .user_lvds(user_lvds), .user_term(user_term),
    .burst_ready(burst_ready), .overtemp(overtemp));
  plsr_pulser i_plsr_pulser (.clock(clock), .reset(reset), .pins(link),
    .die_temp_c(die_temp_c), .ch_switch(ch_switch), .drive_current_mode(drive_current_mode),
    .clocked_active(clocked_active), .lvds_selected(lvds_selected),
    .termination_on(termination_on));
  plsr_asserts i_plsr_asserts (.clock(clock), .reset(reset),
    .channel_code(link.channel_code), .output_enable_n(link.output_enable_n),
    .clock_mode_select_n(link.clock_mode_select_n), .link_clock(link.link_clock),
    .clock_negative(link.clock_negative), .overtemp_flag_o(link.overtemp_flag_o),
    .overtemp_flag_oe_n(link.overtemp_flag_oe_n), .die_temp_c(die_temp_c),
    .ch_switch(ch_switch), .drive_current_mode(drive_current_mode));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("[FAIL] %0t run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic check_val(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask : step

  task automatic restart(input logic [1:0] drv, input logic [1:0] ovl, input logic clk_on);
    user_drive_sel = drv;
    user_overlap_sel = ovl;
    user_clocked = clk_on;
    user_lvds = clk_on;
    user_term = clk_on;
    user_edge_sel = {2{clk_on}};
    user_enable_n = 1'b1;
    user_code = 12'h000;
    reset = 1'b1;
    step(8);
    reset = 1'b0;
    step(2);
  endtask : restart

  task automatic t_truth();
    restart(2'h3, 2'h0, 1'b0);
    check_val(12'(drive_current_mode), 12'h003, "drive mode");
    check_val(12'(clocked_active), 12'h000, "clocked flag");
    check_val(12'(link.clock_interface_select), 12'h001, "cmos select");
    check_val(12'(termination_on), 12'h000, "termination");
    user_enable_n = 1'b0;
    user_code = {4{CODE_GND}};
    step(TX_SETUP_CYC + 2);
    for (int c = 0; c < 8; c++) begin
      user_code = {4{3'(c)}};
      step(6);
      for (int g = 0; g < CH_NUM; g++) check_val(ch_switch[g], EXP[c], "decode");
    end
    user_code = {3'b011, 3'b001, 3'b100, 3'b110};
    step(6);
    for (int g = 0; g < CH_NUM; g++)
      check_val(ch_switch[g], EXP[user_code[3*g+:3]], "lanes");
    user_enable_n = 1'b1;
    step(6);
    for (int g = 0; g < CH_NUM; g++) check_val(ch_switch[g], SW_SAFE, "disabled");
    $display("test truth done");
  endtask : t_truth

  task automatic t_drive();
    for (int d = 0; d < 3; d++) begin
      restart(2'(d), 2'h0, 1'b0);
      check_val(12'(drive_current_mode), 12'(d), "drive mode");
      check_val(12'(link.drive_strength_sel), 12'(d), "drive pin");
      user_enable_n = 1'b0;
      user_code = {4{CODE_GND}};
      step(TX_SETUP_CYC + 2);
      user_code = {3'b101, 3'b001, 3'b101, 3'b001};
      step(6);
      for (int g = 0; g < CH_NUM; g++)
        check_val(ch_switch[g], EXP[user_code[3*g+:3]] & 12'hf3f, "no assist");
    end
    $display("test drive done");
  endtask : t_drive

  task automatic t_overlap();
    int n;
    for (int s = 0; s < 4; s++) begin
      restart(2'h3, 2'(s), 1'b0);
      user_enable_n = 1'b0;
      user_code = {4{3'b010}};
      n = 0;
      repeat (100) begin
        step(1);
        if (ch_switch[0].rx_series_switch_first === 1'b1
            && ch_switch[0].rx_shunt_switch === 1'b1) begin
          n++;
        end
      end
      check_val(12'(n), 12'(OVL[s]), "overlap cycles");
      check_val(ch_switch[3], EXP[2], "receive");
    end
    $display("test overlap done");
  endtask : t_overlap

  task automatic t_burst();
    restart(2'h3, 2'h0, 1'b0);
    user_enable_n = 1'b0;
    user_code = {4{3'b100}};
    step(2);
    check_val(12'(burst_ready), 12'h000, "burst early");
    step(TX_SETUP_CYC + 4);
    check_val(12'(burst_ready), 12'h001, "burst ready");
    user_code[2:0] = 3'b011;
    step(3);
    check_val(12'(burst_ready), 12'h000, "burst dropped");
    $display("test burst done");
  endtask : t_burst

  task automatic t_clocked();
    int n;
    logic prev;
    restart(2'h3, 2'h0, 1'b1);
    check_val(12'(link.clock_mode_select_n), 12'h000, "clock select");
    check_val({link.clock_interface_select, lvds_selected}, 12'h001, "lvds");
    check_val({link.diff_termination_select, termination_on}, 12'h003, "term");
    check_val(12'(link.clock_edge_delay_sel), 12'h003, "edge delay");
    user_enable_n = 1'b0;
    user_code = {4{CODE_GND}};
    step(TX_SETUP_CYC * 2);
    check_val(12'(burst_ready), 12'h000, "clock settle wait");
    step(CLOCK_MODE_SELECT_N_CYC);
    check_val(12'(clocked_active), 12'h001, "clocked");
    check_val(12'(burst_ready), 12'h001, "settled ready");
    user_code = {4{3'b011}};
    n = 0;
    while (ch_switch[0] !== EXP[3] && n < 20) begin
      step(1);
      n++;
    end
    check_val(ch_switch[1], EXP[3], "clocked decode");
    n = 0;
    prev = link.link_clock;
    for (int i = 0; i < 40; i++) begin
      step(1);
      if (link.link_clock === 1'b1 && prev === 1'b0) n++;
      prev = link.link_clock;
    end
    check_val(12'(n), 12'd10, "clock rises");
    $display("test clocked done");
  endtask : t_clocked

  task automatic t_overtemp();
    die_temp_c = 8'h6f;
    step(2);
    check_val(12'(link.overtemp_flag_oe_n), 12'h000, "flag pulled");
    step(3);
    check_val(12'(overtemp), 12'h001, "overtemp seen");
    die_temp_c = 8'h65;
    step(3);
    check_val(12'(link.overtemp_flag_oe_n), 12'h000, "hysteresis");
    die_temp_c = 8'h64;
    step(5);
    check_val({link.overtemp_flag_oe_n, overtemp}, 12'h002, "released");
    $display("test overtemp done");
  endtask : t_overtemp

  initial begin
    reset = 1'b1;
    die_temp_c = 8'h19;
    user_code = 12'h000;
    user_enable_n = 1'b1;
    user_clocked = 1'b0;
    user_drive_sel = 2'h3;
    user_overlap_sel = 2'h0;
    user_edge_sel = 2'h0;
    user_lvds = 1'b0;
    user_term = 1'b0;
    t_truth();
    t_drive();
    t_overlap();
    t_burst();
    t_clocked();
    t_overtemp();
    report_and_stop();
  end
endmodule : pulser_channel_mode_control_test
`default_nettype wire
